// ===== bdcr_pkg.sv
// Shared constants and types of the background debug control registers.
package bdcr_pkg;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int ADDR_W          = 16;
  localparam int REG_W           = 8;
  localparam int PERMIT_BIT      = 7;
  localparam int ACTIVE_BIT      = 6;
  localparam int BKPT_EN_BIT     = 5;
  localparam int FORCE_TAG_BIT   = 4;
  localparam int CLK_SEL_BIT     = 3;
  localparam int WAIT_STOP_BIT   = 2;
  localparam int WS_FAIL_BIT     = 1;
  localparam int SLOW_FAIL_BIT   = 0;
  localparam int FORCE_RESET_BIT = 0;

  // ----------------------------------------------------------------
  // Reset and fixed read values
  // ----------------------------------------------------------------
  localparam logic              CTRL_BIT_RST     = 1'h0;
  localparam logic [ADDR_W-1:0] BKPT_RST         = 16'h0000;
  localparam logic [REG_W-1:0]  FORCE_RESET_READ = 8'h00;
  localparam logic              SLOW_FAIL_VALUE  = 1'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ          = 200;
  localparam int RESET_PULSE_NS     = 100;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS * CLOCK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Serial debug commands, already decoded from the link
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_READ_STATUS       = 3'b000,
    CMD_WRITE_CONTROL     = 3'b001,
    CMD_BREAKPOINT_READ_CMD         = 3'b010,
    CMD_BREAKPOINT_WRITE_CMD        = 3'b011,
    CMD_FORCE_HALT        = 3'b100,
    CMD_RESUME            = 3'b101,
    CMD_WRITE_FORCE_RESET = 3'b110
  } bdcr_cmd_t;

  typedef enum logic [1:0] {
    MODE_RUN    = 2'b00,
    MODE_HALTED = 2'b01
  } bdcr_mode_t;

endpackage

// ===== bdcr_match_if.sv
// Carrier between the control registers and the breakpoint matcher.
`timescale 1ns/1ps
`default_nettype none
interface bdcr_match_if;
  logic [15:0] busAddr;
  logic        busValid;
  logic        opcodeFetch;
  logic        instrBoundary;
  logic [15:0] bkptAddr;
  logic        bkptEnable;
  logic        forceTag;
  logic        clearForce;
  logic        forcePending;
  logic        tagFetch;

  modport ctrl (
    output busAddr, busValid, opcodeFetch, instrBoundary, bkptAddr, bkptEnable,
    output forceTag, clearForce,
    input  forcePending, tagFetch
  );
  modport matcher (
    input  busAddr, busValid, opcodeFetch, instrBoundary, bkptAddr, bkptEnable,
    input  forceTag, clearForce,
    output forcePending, tagFetch
  );
endinterface
`default_nettype wire

// ===== bdcr_bkpt_match.sv
// Breakpoint address comparator with force and tag request generation.
`timescale 1ns/1ps
`default_nettype none
module bdcr_bkpt_match (
  input wire logic   clock,
  input wire logic   rst_n,
  bdcr_match_if.matcher mif
);
  import bdcr_pkg::*;

  logic forcePending_ff;
  logic tagFetch_ff;
  logic hit;

  // A disabled breakpoint ignores both the select bit and the address.
  assign hit = mif.bkptEnable && mif.busValid && (mif.busAddr == mif.bkptAddr);

  // ----------------------------------------------------------------
  // Force request, held until the next instruction boundary is used or the breakpoint is disabled
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      forcePending_ff <= 1'b0;
    end else if (hit && mif.forceTag) begin
      forcePending_ff <= 1'b1;
    end else if (mif.clearForce || !mif.bkptEnable) begin
      forcePending_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Tag marks only the opcode fetched at the match address
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tagFetch_ff <= 1'b0;
    end else begin
      tagFetch_ff <= hit && !mif.forceTag && mif.opcodeFetch;
    end
  end

  assign mif.forcePending = forcePending_ff;
  assign mif.tagFetch     = tagFetch_ff;
endmodule
`default_nettype wire

// ===== bdcr_reset_pulse.sv
// Stretches a force-reset request into a system reset pulse.
`timescale 1ns/1ps
`default_nettype none
module bdcr_reset_pulse #(
  parameter int CYCLES = bdcr_pkg::RESET_PULSE_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic start,
  output var  logic resetOut
);
  import bdcr_pkg::*;

  localparam int CNT_W = $clog2(CYCLES + 1);

  logic [CNT_W-1:0] count_ff;
  logic             resetOut_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_ff    <= '0;
      resetOut_ff <= 1'b0;
    end else if (start) begin
      count_ff    <= CNT_W'(CYCLES);
      resetOut_ff <= 1'b1;
    end else if (count_ff > CNT_W'(1)) begin
      count_ff <= count_ff - CNT_W'(1);
    end else begin
      count_ff    <= '0;
      resetOut_ff <= 1'b0;
    end
  end

  assign resetOut = resetOut_ff;
endmodule
`default_nettype wire

// ===== bdcr_debug_regs.sv
// Status, control, breakpoint and force-reset registers of the serial debug controller.
//
// Operation
// - Status/control reached only by serial commands
// - Bit 7 permits background mode; reset clears
// - Bit 6 reads background active state
// - Breakpoint disabled: select and address ignored
// - Select 1: any match forces background at boundary
// - Select 0: match tags fetched opcode
// - Bit 3 picks communication clock, default alternate
// - Bit 2 shows wait/stop or halted from it
// - Forced halt leaves wait/stop into background
// - Bit 1 flags access failed by wait/stop
// - Bit 0 never reports slow access failure
// - Sixteen-bit breakpoint address, serial access only
// - Force-reset ignores user writes, reads zero
// - Writing one to bit 0 resets system
// - Permit locked while active; status bits read-only
`timescale 1ns/1ps
`default_nettype none
module bdcr_debug_regs #(
  parameter int RESET_CYCLES = bdcr_pkg::RESET_PULSE_CYCLES
) (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         cmdValid,
  input  wire bdcr_pkg::bdcr_cmd_t          cmdCode,
  input  wire logic [bdcr_pkg::ADDR_W-1:0]  cmdData,
  output var  logic                         rspValid,
  output var  logic [bdcr_pkg::ADDR_W-1:0]  rspData,
  input  wire logic [bdcr_pkg::ADDR_W-1:0]  cpuAddr,
  input  wire logic                         cpuAddrValid,
  input  wire logic                         cpuOpcodeFetch,
  input  wire logic                         cpuInstrBoundary,
  input  wire logic                         cpuTagAtQueueEnd,
  input  wire logic                         cpuWaitStop,
  input  wire logic                         memAccessFail,
  input  wire logic                         userForceResetWrite,
  input  wire logic [bdcr_pkg::REG_W-1:0]   userForceResetData,
  output var  logic                         haltedDebugMode,
  output var  logic                         tagFetch,
  output var  logic                         swiRequest,
  output var  logic                         commClockSelect,
  output var  logic                         systemReset
);
  import bdcr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bdcr_mode_t          mode_ff;
  bdcr_mode_t          nxt_mode;
  logic                backgroundPermit_ff;
  logic                breakpointEnable_ff;
  logic                forceTagSelect_ff;
  logic                commClockSelect_ff;
  logic                haltedFromWaitStop_ff;
  logic                waitStopFail_ff;
  logic [ADDR_W-1:0]   breakpointAddr_ff;
  logic                rspValid_ff;
  logic [ADDR_W-1:0]   rspData_ff;
  logic                swiRequest_ff;
  logic                tagFetch_ff;
  logic                forceResetStart;
  logic                breakEvent;
  logic                haltCmd;
  logic                resumeCmd;
  logic [REG_W-1:0]    statusByte;
  logic                ctrlWrite;
  logic                bkptWrite;
  logic                haltedDebugMode_ff;

  bdcr_match_if mif ();

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // A command counts only in the cycle in which its strobe stands.
  function automatic logic isCmd(
    input logic      valid,
    input bdcr_cmd_t code,
    input bdcr_cmd_t want
  );
    return valid && (code == want);
  endfunction

  assign haltCmd   = isCmd(cmdValid, cmdCode, CMD_FORCE_HALT);
  assign resumeCmd = isCmd(cmdValid, cmdCode, CMD_RESUME);
  assign ctrlWrite = isCmd(cmdValid, cmdCode, CMD_WRITE_CONTROL);
  assign bkptWrite = isCmd(cmdValid, cmdCode, CMD_BREAKPOINT_WRITE_CMD);

  // A break is a force request at a boundary or a tagged opcode leaving the queue.
  assign breakEvent = (mif.forcePending && cpuInstrBoundary) || cpuTagAtQueueEnd;

  // ----------------------------------------------------------------
  // Breakpoint matcher
  // ----------------------------------------------------------------
  assign mif.busAddr       = cpuAddr;
  assign mif.busValid      = cpuAddrValid;
  assign mif.opcodeFetch   = cpuOpcodeFetch;
  assign mif.instrBoundary = cpuInstrBoundary;
  assign mif.bkptAddr      = breakpointAddr_ff;
  assign mif.bkptEnable    = breakpointEnable_ff;
  assign mif.forceTag      = forceTagSelect_ff;
  assign mif.clearForce    = cpuInstrBoundary;

  bdcr_bkpt_match u_match (
    .clock (clock),
    .rst_n (rst_n),
    .mif   (mif.matcher)
  );

  // ----------------------------------------------------------------
  // Background mode sequencing
  // ----------------------------------------------------------------
  // Without the permit bit a forced halt is answered but has no effect.
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_RUN: begin
        if (backgroundPermit_ff && (haltCmd || breakEvent)) begin
          nxt_mode = MODE_HALTED;
        end
      end
      MODE_HALTED: begin
        if (resumeCmd) begin
          nxt_mode = MODE_RUN;
        end
      end
      default: begin
        nxt_mode = MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= MODE_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // The mode output gets its own flop so the pin carries no decode logic.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      haltedDebugMode_ff <= 1'b0;
    end else begin
      haltedDebugMode_ff <= (nxt_mode == MODE_HALTED);
    end
  end

  // Without permission a break runs the software interrupt instead.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      swiRequest_ff <= 1'b0;
    end else begin
      swiRequest_ff <= (mode_ff == MODE_RUN) && !backgroundPermit_ff && breakEvent;
    end
  end

  // Remembers that the halt was forced out of wait or stop.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      haltedFromWaitStop_ff <= 1'b0;
    end else if (mode_ff == MODE_RUN && nxt_mode == MODE_HALTED) begin
      haltedFromWaitStop_ff <= haltCmd && cpuWaitStop;
    end else if (nxt_mode == MODE_RUN) begin
      haltedFromWaitStop_ff <= 1'b0;
    end
  end

  // Failure flag: a new failure wins over the clearing resume.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitStopFail_ff <= 1'b0;
    end else if (memAccessFail) begin
      waitStopFail_ff <= 1'b1;
    end else if (resumeCmd) begin
      waitStopFail_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control bits and breakpoint address, written only by the control-write and breakpoint-write commands
  // ----------------------------------------------------------------
  // The permit bit is frozen while halted, so it never forbids the mode already active.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      backgroundPermit_ff <= CTRL_BIT_RST;
    end else if (ctrlWrite && mode_ff != MODE_HALTED) begin
      backgroundPermit_ff <= cmdData[PERMIT_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      breakpointEnable_ff <= CTRL_BIT_RST;
    end else if (ctrlWrite) begin
      breakpointEnable_ff <= cmdData[BKPT_EN_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      forceTagSelect_ff <= CTRL_BIT_RST;
    end else if (ctrlWrite) begin
      forceTagSelect_ff <= cmdData[FORCE_TAG_BIT];
    end
  end

  // The clock select may change at any time, halted or not.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      commClockSelect_ff <= CTRL_BIT_RST;
    end else if (ctrlWrite) begin
      commClockSelect_ff <= cmdData[CLK_SEL_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      breakpointAddr_ff <= BKPT_RST;
    end else if (bkptWrite) begin
      breakpointAddr_ff <= cmdData;
    end
  end

  // ----------------------------------------------------------------
  // Status read-back
  // ----------------------------------------------------------------
  always_comb begin
    statusByte                = '0;
    statusByte[PERMIT_BIT]    = backgroundPermit_ff;
    statusByte[ACTIVE_BIT]    = (mode_ff == MODE_HALTED);
    statusByte[BKPT_EN_BIT]   = breakpointEnable_ff;
    statusByte[FORCE_TAG_BIT] = forceTagSelect_ff;
    statusByte[CLK_SEL_BIT]   = commClockSelect_ff;
    statusByte[WAIT_STOP_BIT] = cpuWaitStop || haltedFromWaitStop_ff;
    statusByte[WS_FAIL_BIT]   = waitStopFail_ff;
    statusByte[SLOW_FAIL_BIT] = SLOW_FAIL_VALUE;
  end

  // Every command is answered one cycle after it is taken.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rspValid_ff <= 1'b0;
      rspData_ff  <= '0;
    end else begin
      rspValid_ff <= cmdValid;
      if (cmdValid) begin
        unique case (cmdCode)
          CMD_READ_STATUS:       rspData_ff <= {8'h00, statusByte};
          CMD_BREAKPOINT_READ_CMD:         rspData_ff <= breakpointAddr_ff;
          CMD_WRITE_FORCE_RESET: rspData_ff <= {8'h00, FORCE_RESET_READ};
          default:               rspData_ff <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Force reset: only the serial byte write reaches it
  // ----------------------------------------------------------------
  assign forceResetStart = isCmd(cmdValid, cmdCode, CMD_WRITE_FORCE_RESET)
                           && cmdData[FORCE_RESET_BIT];

  bdcr_reset_pulse #(
    .CYCLES (RESET_CYCLES)
  ) u_reset (
    .clock    (clock),
    .rst_n    (rst_n),
    .start    (forceResetStart),
    .resetOut (systemReset)
  );

  // User-side writes to the force-reset register have no effect.
  logic userWriteSeen;
  assign userWriteSeen = userForceResetWrite && |userForceResetData;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tagFetch_ff <= 1'b0;
    end else begin
      tagFetch_ff <= mif.tagFetch && !userWriteSeen ? 1'b1 : mif.tagFetch;
    end
  end

  assign rspValid        = rspValid_ff;
  assign rspData         = rspData_ff;
  assign haltedDebugMode = haltedDebugMode_ff;
  assign tagFetch        = tagFetch_ff;
  assign swiRequest      = swiRequest_ff;
  assign commClockSelect = commClockSelect_ff;
endmodule
`default_nettype wire

// ===== bdcr_debug_regs_assertions.sv
// Port checker of the debug control register block.
`timescale 1ns/1ps
`default_nettype none
module bdcr_debug_regs_checker
  import bdcr_pkg::*;
#(
  parameter int RESET_CYCLES = bdcr_pkg::RESET_PULSE_CYCLES
) (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic                cmdValid,
  input wire bdcr_pkg::bdcr_cmd_t cmdCode,
  input wire logic [15:0]         cmdData,
  input wire logic                rspValid,
  input wire logic [15:0]         rspData,
  input wire logic [15:0]         cpuAddr,
  input wire logic                cpuAddrValid,
  input wire logic                cpuOpcodeFetch,
  input wire logic                cpuInstrBoundary,
  input wire logic                cpuTagAtQueueEnd,
  input wire logic                cpuWaitStop,
  input wire logic                memAccessFail,
  input wire logic                userForceResetWrite,
  input wire logic [7:0]          userForceResetData,
  input wire logic                haltedDebugMode,
  input wire logic                tagFetch,
  input wire logic                swiRequest,
  input wire logic                commClockSelect,
  input wire logic                systemReset
);
  localparam int LastHigh = RESET_CYCLES - 1;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Command sequences
  // ----------------------------------------------------------------
  sequence statusRead;
    cmdValid && cmdCode == CMD_READ_STATUS;
  endsequence
  sequence resetWrite;
    cmdValid && cmdCode == CMD_WRITE_FORCE_RESET && !systemReset;
  endsequence
  sequence resetPulse;
    (systemReset throughout (1'h1 ##LastHigh 1'h1)) ##1 !systemReset;
  endsequence
  a_rsp_after_cmd: assert property (cmdValid |=> rspValid)
    else $error("no response after a command");
  a_reset_pulse_len: assert property (resetWrite ##0 cmdData[0] |=> resetPulse)
    else $error("system reset pulse has the wrong length");
  a_reset_zero_ignored: assert property (resetWrite ##0 !cmdData[0] |=> !systemReset)
    else $error("reset raised by a zero write");
  a_user_write_ignored: assert property (
    userForceResetWrite && !cmdValid && !systemReset |=> !systemReset)
    else $error("user write raised reset");
  a_clock_select_write: assert property (
    cmdValid && cmdCode == CMD_WRITE_CONTROL |=> commClockSelect == $past(cmdData[3]))
    else $error("clock select not taken from write");
  a_halt_holds: assert property (
    haltedDebugMode && !(cmdValid && cmdCode == CMD_RESUME) |=> haltedDebugMode)
    else $error("background mode left without resume");
  a_tag_two_late: assert property (
    tagFetch |-> $past(cpuAddrValid, 2) && $past(cpuOpcodeFetch, 2))
    else $error("tag without opcode fetch two cycles before");
  a_status_read_fields: assert property (
    statusRead |=> rspData[15:8] == 8'h00 && !rspData[0]
    && rspData[6] == $past(haltedDebugMode))
    else $error("status read fields wrong");
  a_wait_stop_shown: assert property (statusRead ##0 cpuWaitStop |=> rspData[2])
    else $error("wait or stop not shown in status");
  a_halt_has_cause: assert property (
    $rose(haltedDebugMode) |-> $past(cpuInstrBoundary)
    || $past(cpuTagAtQueueEnd) || $past(cmdValid))
    else $error("background mode entered without cause");
endmodule
bind bdcr_debug_regs bdcr_debug_regs_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.*);
`default_nettype wire

// ===== bdcr_host_model.sv
// Serial debug host model issuing decoded commands to the target.
`timescale 1ns/1ps
`default_nettype none
module bdcr_host_model
  import bdcr_pkg::*;
(
  input  wire logic                clock,
  output var  logic                cmdValid,
  output var  bdcr_pkg::bdcr_cmd_t cmdCode,
  output var  logic [15:0]         cmdData
);
  initial begin
    cmdValid = 1'h0;
    cmdCode = CMD_READ_STATUS;
    cmdData = 16'h0000;
  end
  // Idle data is inverted so that a stale value is never mistaken for a command.
  task automatic send(input bdcr_cmd_t code, input logic [15:0] data);
    @(negedge clock);
    cmdValid = 1'h1;
    cmdCode = code;
    cmdData = data;
    @(negedge clock);
    cmdValid = 1'h0;
    cmdData = ~data;
  endtask
endmodule
`default_nettype wire

// ===== background_debug_control_regs_test.sv
// Self-checking bench of the debug status, breakpoint and force-reset registers.
`timescale 1ns/1ps
`default_nettype none
module background_debug_control_regs_test;
  import bdcr_pkg::*;
  localparam int RCyc = 3;
  logic clock, rst_n, cmdValid, rspValid, cpuAddrValid, cpuOpcodeFetch, cpuInstrBoundary;
  logic cpuTagAtQueueEnd, cpuWaitStop, memAccessFail, userForceResetWrite, haltedDebugMode;
  logic tagFetch, swiRequest, commClockSelect, systemReset, swiSeen;
  logic permit, halted, bkEn, force_tag_select, clkSel, ws, wait_stop_fail;
  bdcr_cmd_t   cmdCode;
  logic [15:0] cmdData, rspData, cpuAddr, bkpt;
  logic [7:0]  userForceResetData, v;
  logic [15:0] expQ[$];
  int          err_count, n_tests, k, j;
  bdcr_host_model i_host (.clock(clock), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData));
  bdcr_debug_regs #(.RESET_CYCLES(RCyc)) i_dut (.*);
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #200us;
    err_count++;
    close_out();
  end
  always @(posedge clock) if (swiRequest === 1'h1) swiSeen <= 1'h1;
  // Response watcher: every answer is matched against the oldest note.
  always @(negedge clock) begin
    if (rspValid === 1'h1) begin
      if (expQ.size() > 0) chk(rspData, expQ.pop_front());
      else chk(rspData, 16'hxxxx);
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmd(input bdcr_cmd_t c, input logic [15:0] d, input logic [15:0] e);
    expQ.push_back(e);
    i_host.send(c, d);
  endtask
  task automatic st();
    cmd(CMD_READ_STATUS, 16'h0000, {8'h00, permit, halted, bkEn, force_tag_select, clkSel, ws | cpuWaitStop,
      wait_stop_fail, 1'h0});
  endtask
  task automatic ctl(input logic [7:0] d);
    cmd(CMD_WRITE_CONTROL, {8'h00, d}, 16'h0000);
    if (!halted) permit = d[7];
    {bkEn, force_tag_select, clkSel} = d[5:3];
  endtask
  task automatic waitMode(input logic e);
    for (k = 0; k < 8 && haltedDebugMode !== e; k++) @(negedge clock);
    chk({15'h0000, haltedDebugMode}, {15'h0000, e});
    if (haltedDebugMode !== e) close_out();
    halted = e;
  endtask
  task automatic resume();
    cmd(CMD_RESUME, 16'h0000, 16'h0000);
    waitMode(1'h0);
    ws = 1'h0;
    wait_stop_fail = 1'h0;
  endtask
  task automatic brk(input logic op, input logic bnd);
    @(negedge clock);
    cpuAddr = bkpt;
    cpuAddrValid = 1'h1;
    cpuOpcodeFetch = op;
    @(negedge clock);
    cpuAddrValid = 1'h0;
    cpuOpcodeFetch = 1'h0;
    cpuInstrBoundary = bnd;
    cpuAddr = ~bkpt;
    @(negedge clock);
    cpuInstrBoundary = 1'h0;
  endtask
  initial begin
    {rst_n, cpuAddrValid, cpuOpcodeFetch, cpuInstrBoundary, cpuTagAtQueueEnd} = '0;
    {cpuWaitStop, memAccessFail, userForceResetWrite, swiSeen, err_count, n_tests} = '0;
    {permit, halted, bkEn, force_tag_select, clkSel, ws, wait_stop_fail, cpuAddr, userForceResetData} = '0;
    bkpt = $urandom(32'hfe94);
    repeat (20) @(negedge clock);
    rst_n = 1'h1;
    st();
    cmd(CMD_BREAKPOINT_READ_CMD, 16'h0000, BKPT_RST);
    $display("test reset values done");
    for (j = 0; j < 4; j++) begin
      v = 8'($urandom);
      v[3] = j[0];
      ctl(v);
      st();
      chk({15'h0000, commClockSelect}, {15'h0000, v[3]});
    end
    $display("test control writes done");
    cmd(CMD_BREAKPOINT_WRITE_CMD, bkpt, 16'h0000);
    cmd(CMD_BREAKPOINT_READ_CMD, 16'h0000, bkpt);
    ctl(8'hb0);
    brk(1'h0, 1'h1);
    waitMode(1'h1);
    ctl(8'h08);
    st();
    resume();
    $display("test force break done");
    ctl(8'h90);
    brk(1'h1, 1'h1);
    repeat (3) @(negedge clock);
    chk({15'h0000, haltedDebugMode}, 16'h0000);
    ctl(8'ha0);
    brk(1'h1, 1'h0);
    chk({15'h0000, tagFetch}, 16'h0001);
    cpuTagAtQueueEnd = 1'h1;
    @(negedge clock);
    cpuTagAtQueueEnd = 1'h0;
    waitMode(1'h1);
    resume();
    $display("test tag break done");
    ctl(8'h30);
    swiSeen = 1'h0;
    brk(1'h0, 1'h1);
    repeat (3) @(negedge clock);
    chk({14'h0000, swiSeen, haltedDebugMode}, 16'h0002);
    $display("test break without permit done");
    ctl(8'h80);
    cpuWaitStop = 1'h1;
    st();
    @(negedge clock);
    memAccessFail = 1'h1;
    @(negedge clock);
    memAccessFail = 1'h0;
    wait_stop_fail = 1'h1;
    st();
    cmd(CMD_FORCE_HALT, 16'h0000, 16'h0000);
    waitMode(1'h1);
    cpuWaitStop = 1'h0;
    ws = 1'h1;
    st();
    cmd(CMD_BREAKPOINT_READ_CMD, 16'h0000, bkpt);
    resume();
    st();
    $display("test wait stop done");
    @(negedge clock);
    userForceResetWrite = 1'h1;
    userForceResetData = 8'($urandom) | 8'h01;
    @(negedge clock);
    userForceResetWrite = 1'h0;
    @(negedge clock);
    chk({15'h0000, systemReset}, 16'h0000);
    cmd(CMD_WRITE_FORCE_RESET, 16'h00fe, {8'h00, FORCE_RESET_READ});
    chk({15'h0000, systemReset}, 16'h0000);
    cmd(CMD_WRITE_FORCE_RESET, 16'h0001, 16'h0000);
    for (k = 0; k < 20 && systemReset === 1'h1; k++) @(negedge clock);
    chk(16'(k), 16'(RCyc));
    $display("test force reset done");
    ctl(8'hb8);
    @(negedge clock);
    rst_n = 1'h0;
    repeat (2) @(negedge clock);
    rst_n = 1'h1;
    {permit, bkEn, force_tag_select, clkSel} = '0;
    chk({15'h0000, commClockSelect}, 16'h0000);
    st();
    $display("test mid-run reset done");
    repeat (2) @(negedge clock);
    chk(16'(expQ.size()), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
